// [hw/capcmp_pkg.sv]
// Constants shared by the capture/compare/PWM unit
package capcmp_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA_LO = 8'h04;
  localparam logic [7:0] OFF_DATA_HI = 8'h08;
  localparam logic [7:0] OFF_TIMER_ASSIGN = 8'h0C;
  localparam logic [7:0] OFF_FIRST_TIMER_HIGH_BYTE_OVERLAY = 8'h10;
  localparam logic [7:0] OFF_SHADOW = 8'h14;
  localparam logic [7:0] OFF_FLAG = 8'h18;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DUTY_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'h3F;
  // Mode field encodings
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_RSVD_A = 4'h1;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_RSVD_B = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
  // Prescaler terminal counts (edges minus one)
  localparam logic [3:0] PRESC_LAST4 = 4'h3;
  localparam logic [3:0] PRESC_LAST16 = 4'hF;
  // Timer interconnect options
  localparam logic [1:0] ASSIGN_ALL_LOW = 2'h0;
  localparam logic [1:0] ASSIGN_FIRST_ENH = 2'h1;
  localparam logic [1:0] ASSIGN_TWO_ENH = 2'h2;
  localparam logic [1:0] ASSIGN_ALL_HIGH = 2'h3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/capcmp_unit.sv]
// Standard capture/compare/PWM unit with AXI4-Lite register slave
// Overview of operation
// - Mode zero disables and clears; reserved codes idle.
// - Codes 4-7 select falling/rising/4th/16th edge capture.
// - Code 2 toggles pin on match, sets flag.
// - Code 8 starts pin low, match forces high.
// - Code 9 starts pin high, match forces low.
// - Code A only flags; pin follows port latch.
// - Code B flags and pulses special event.
// - Codes 11xx are PWM with 10-bit duty.
// - Data bytes read/write; control bits 7:6 read zero.
// - Capture/compare uses 16-bit timer, PWM 8-bit.
// - Four timer interconnect options are supported.
// - Open-drain bit overlays timer high byte address.
// - Capture copies full 16-bit timer value.
// - Every capture sets flag until software clears.
// - New capture overwrites old value, no lock.
// - Edges observed on pad, so port writes capture.
// - Prescaler clears when off or capture left.
// - Prescale change keeps count, may raise flag.
// - Compare data with timer, act on equality.
`timescale 1ns/1ps
module capcmp_unit
  import capcmp_pkg::*;
#(
  parameter int UNIT_INDEX = 3
)(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // AXI4-Lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Shared timers
  input wire logic [15:0] first_timer_i,
  input wire logic [15:0] third_timer_i,
  input wire logic [7:0] second_timer_i,
  input wire logic [7:0] fourth_timer_i,
  // Pin and port
  input wire logic pin_i,
  input wire logic port_latch_i,
  input wire logic pin_direction_bit_i,
  output logic pin_o,
  output logic pin_oe_o,
  // Events
  output logic unit_interrupt_flag_o,
  output logic special_event_o,
  output logic [9:0] pwm_duty_o
);

  // Interconnect decode: does this unit sit on the first/second timers
  function automatic logic uses_low_pair(input logic [1:0] code);
    case (code)
      ASSIGN_ALL_LOW: uses_low_pair = 1'b1;
      ASSIGN_FIRST_ENH: uses_low_pair = (UNIT_INDEX < 1);
      ASSIGN_TWO_ENH: uses_low_pair = (UNIT_INDEX < 2);
      default: uses_low_pair = 1'b0;
    endcase
  endfunction

  // Register state
  logic [7:0] unit_control_reg;
  logic [7:0] data_lo_reg;
  logic [7:0] data_hi_reg;
  logic [1:0] timer_assign_reg;
  logic open_drain_reg;
  logic shadow_select_reg;
  logic flag_reg;
  logic special_reg;
  logic [9:0] duty_reg;
  // Unit state
  logic [3:0] prev_mode_reg;
  logic [3:0] presc_reg;
  logic cmp_latch_reg;
  logic match_prev_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  // Bus state
  logic aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic w_strb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Mode decoding
  wire logic [3:0] mode = unit_control_reg[CTRL_MODE_LSB +: 4];
  wire logic [1:0] duty_bits = unit_control_reg[CTRL_DUTY_LSB +: 2];
  wire logic is_capture = (mode[3:2] == 2'h1);
  wire logic is_compare = (mode == MODE_TOGGLE) || (mode[3:2] == 2'h2);
  wire logic is_pwm = (mode[3:2] == 2'h3);
  wire logic entering = (mode != prev_mode_reg);

  // Timer selection
  wire logic low_pair = uses_low_pair(timer_assign_reg);
  wire logic [15:0] timer16 = low_pair ? first_timer_i : third_timer_i;
  wire logic [7:0] timer8 = low_pair ? second_timer_i : fourth_timer_i;
  wire logic [15:0] data16 = {data_hi_reg, data_lo_reg};

  // Edge detection on the synchronized pad level
  wire logic rise = sync2_reg && !sync3_reg;
  wire logic fall = !sync2_reg && sync3_reg;
  wire logic presc_step = rise && (mode == MODE_CAP_RISE4 || mode == MODE_CAP_RISE16);
  wire logic [3:0] presc_last = (mode == MODE_CAP_RISE16) ? PRESC_LAST16 : PRESC_LAST4;
  wire logic cap_fire = (mode == MODE_CAP_FALL && fall) || (mode == MODE_CAP_RISE && rise) ||
                        (presc_step && presc_reg == presc_last);
  wire logic [3:0] presc_next = !is_capture ? 4'h0 :
                                !presc_step ? presc_reg :
                                (presc_reg == presc_last) ? 4'h0 : presc_reg + 4'h1;

  // Compare equality, acted on at its first cycle only
  wire logic match_now = (timer16 == data16);
  wire logic match_evt = is_compare && match_now && !match_prev_reg;

  // Compare output latch next value
  wire logic latch_next = (mode == MODE_OFF) ? 1'b0 :
                          (entering && mode == MODE_CMP_HIGH) ? 1'b0 :
                          (entering && mode == MODE_CMP_LOW) ? 1'b1 :
                          (match_evt && mode == MODE_TOGGLE) ? !cmp_latch_reg :
                          (match_evt && mode == MODE_CMP_HIGH) ? 1'b1 :
                          (match_evt && mode == MODE_CMP_LOW) ? 1'b0 : cmp_latch_reg;

  // Pin drive with optional open drain
  wire logic pwm_level = ({timer8, 2'h0} < duty_reg);
  wire logic unit_drives = is_pwm || (is_compare && mode != MODE_CMP_SOFT);
  wire logic pin_value = !unit_drives ? port_latch_i : is_pwm ? pwm_level : cmp_latch_reg;
  wire logic od_active = open_drain_reg && (is_compare || is_pwm);
  assign pin_o = od_active ? 1'b0 : pin_value;
  assign pin_oe_o = !pin_direction_bit_i && (!od_active || !pin_value);

  // Bus handshakes and write decode
  assign awready_o = ce_i && !aw_hold_reg;
  assign wready_o = ce_i && !w_hold_reg;
  assign arready_o = ce_i && !rvalid_reg;
  wire logic aw_take = awvalid_i && awready_o;
  wire logic w_take = wvalid_i && wready_o;
  wire logic ar_take = arvalid_i && arready_o;
  wire logic do_write = ce_i && aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire logic wr_ok = do_write && w_strb0_reg;
  wire logic [7:0] wbyte = w_data_reg[7:0];
  wire logic wr_ctrl = wr_ok && aw_addr_reg == OFF_CTRL;
  wire logic wr_lo = wr_ok && aw_addr_reg == OFF_DATA_LO;
  wire logic wr_hi = wr_ok && aw_addr_reg == OFF_DATA_HI;
  wire logic wr_assign = wr_ok && aw_addr_reg == OFF_TIMER_ASSIGN;
  wire logic wr_od = wr_ok && aw_addr_reg == OFF_FIRST_TIMER_HIGH_BYTE_OVERLAY && shadow_select_reg;
  wire logic wr_shadow = wr_ok && aw_addr_reg == OFF_SHADOW;
  wire logic flag_clr = wr_ok && aw_addr_reg == OFF_FLAG && wbyte[0];
  wire logic flag_set = cap_fire || match_evt;
  wire logic aw_mapped = (aw_addr_reg <= OFF_FLAG) && (aw_addr_reg[1:0] == 2'h0);

  // Read mux
  wire logic ar_mapped = (araddr_i <= OFF_FLAG) && (araddr_i[1:0] == 2'h0);
  wire logic [7:0] overlay_byte = shadow_select_reg ? {7'h00, open_drain_reg} : first_timer_i[15:8];
  wire logic [7:0] rd_byte = (araddr_i == OFF_CTRL) ? (unit_control_reg & CTRL_IMPL_MASK) :
                             (araddr_i == OFF_DATA_LO) ? data_lo_reg :
                             (araddr_i == OFF_DATA_HI) ? data_hi_reg :
                             (araddr_i == OFF_TIMER_ASSIGN) ? {6'h00, timer_assign_reg} :
                             (araddr_i == OFF_FIRST_TIMER_HIGH_BYTE_OVERLAY) ? overlay_byte :
                             (araddr_i == OFF_SHADOW) ? {7'h00, shadow_select_reg} :
                             (araddr_i == OFF_FLAG) ? {7'h00, flag_reg} : 8'h00;

  // Pin synchronizer
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      unit_control_reg <= CTRL_RESET;
      timer_assign_reg <= ASSIGN_ALL_LOW;
      open_drain_reg <= 1'b0;
      shadow_select_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
        unit_control_reg <= wbyte & CTRL_IMPL_MASK;
      if (wr_assign)
        timer_assign_reg <= wbyte[1:0];
      if (wr_od)
        open_drain_reg <= wbyte[0];
      if (wr_shadow)
        shadow_select_reg <= wbyte[0];
    end
  end

  // Data pair: a capture beats a software write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      data_lo_reg <= 8'h00;
      data_hi_reg <= 8'h00;
    end
    else if (ce_i)
    begin
      if (cap_fire)
      begin
        data_lo_reg <= timer16[7:0];
        data_hi_reg <= timer16[15:8];
      end
      else
      begin
        if (wr_lo)
          data_lo_reg <= wbyte;
        if (wr_hi)
          data_hi_reg <= wbyte;
      end
    end
  end

  // Unit state: flag, prescaler, compare latch, special event
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      flag_reg <= 1'b0;
      special_reg <= 1'b0;
      duty_reg <= 10'h000;
      prev_mode_reg <= MODE_OFF;
      presc_reg <= 4'h0;
      cmp_latch_reg <= 1'b0;
      match_prev_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      flag_reg <= flag_set || (flag_reg && !flag_clr);
      special_reg <= match_evt && mode == MODE_CMP_SPECIAL;
      duty_reg <= is_pwm ? {data_lo_reg, duty_bits} : 10'h000;
      prev_mode_reg <= mode;
      presc_reg <= presc_next;
      cmp_latch_reg <= latch_next;
      match_prev_reg <= is_compare && match_now;
    end
  end

  // AXI write channel
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (aw_take)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= awaddr_i;
      end
      else if (do_write)
        aw_hold_reg <= 1'b0;
      if (w_take)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= wdata_i;
        w_strb0_reg <= wstrb_i[0];
      end
      else if (do_write)
        w_hold_reg <= 1'b0;
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready_i)
        bvalid_reg <= 1'b0;
    end
  end

  // AXI read channel
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= {24'h000000, rd_byte};
        rresp_reg <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready_i)
        rvalid_reg <= 1'b0;
    end
  end

  // Output drive
  assign bvalid_o = bvalid_reg;
  assign bresp_o = bresp_reg;
  assign rvalid_o = rvalid_reg;
  assign rdata_o = rdata_reg;
  assign rresp_o = rresp_reg;
  assign unit_interrupt_flag_o = flag_reg;
  assign special_event_o = special_reg;
  assign pwm_duty_o = duty_reg;

  // Checks
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flag_reg && !(ce_i && flag_clr) |=> flag_reg)
    else $error("flag dropped without a clear");
  a_capture_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && cap_fire |=> data16 == $past(timer16))
    else $error("capture did not load timer value");
  a_off_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && mode == MODE_OFF |=> presc_reg == 4'h0 && !cmp_latch_reg)
    else $error("disabled unit kept state");
  a_toggle_match: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && match_evt && mode == MODE_TOGGLE && !entering |=> cmp_latch_reg != $past(cmp_latch_reg) && flag_reg)
    else $error("toggle on match failed");
  a_force_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && entering && mode == MODE_CMP_HIGH |=> !cmp_latch_reg)
    else $error("set-high mode did not start low");
  a_force_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && match_evt && mode == MODE_CMP_LOW && !entering |=> !cmp_latch_reg && flag_reg)
    else $error("set-low mode did not force low");
  a_special_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && match_evt && mode == MODE_CMP_SPECIAL |=> special_event_o && flag_reg)
    else $error("special event missing");
  a_soft_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == MODE_CMP_SOFT && !open_drain_reg |-> pin_o == port_latch_i)
    else $error("soft interrupt mode disturbed pin");
  a_pwm_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_pwm |=> pwm_duty_o == $past({data_lo_reg, duty_bits}))
    else $error("pwm duty assembled wrongly");
  a_rise16_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && is_capture && presc_step && presc_reg != presc_last |=> presc_reg == $past(presc_reg) + 4'h1)
    else $error("prescaler did not advance");

endmodule

// [verif/pin_source.sv]
// Pad model: an outside source, a pull-up and the unit's own driver
`timescale 1ns/1ps
module pin_source (
  // Outside source
  input wire logic ext_en_i,
  input wire logic ext_level_i,
  // Unit driver
  input wire logic unit_level_i,
  input wire logic unit_oe_i,
  // Resolved pad level
  output logic pad_o
);
  // Unit wins while it drives, else the source; a released pad floats up
  assign pad_o = unit_oe_i ? unit_level_i : (ext_en_i ? ext_level_i : 1'h1);
endmodule

// [verif/tb.sv]
// Self-checking testbench for the capture/compare/PWM unit
`timescale 1ns/1ps
module tb
  import capcmp_pkg::*;
;
  logic clk_i, rst_n_i, ce_i, awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
  logic arvalid_i, arready_o, rvalid_o, rready_i, pin_i, port_latch, dir_in, pin_o, pin_oe_o;
  logic flag_o, special_o, ext_en, ext_level;
  logic [7:0] awaddr_i, araddr_i, second_timer, fourth_timer;
  logic [31:0] wdata_i, rdata_o, d;
  logic [3:0] wstrb_i;
  logic [1:0] bresp_o, rresp_o, r;
  logic [15:0] first_timer, third_timer;
  logic [9:0] pwm_duty_o;
  logic [3:0] cm [5];
  int n_mismatch, checked, k, n, s;
  int n_spec = 0;

  capcmp_unit capcmp_unit_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .first_timer_i(first_timer), .third_timer_i(third_timer),
    .second_timer_i(second_timer), .fourth_timer_i(fourth_timer),
    .pin_i(pin_i), .port_latch_i(port_latch), .pin_direction_bit_i(dir_in),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .unit_interrupt_flag_o(flag_o),
    .special_event_o(special_o), .pwm_duty_o(pwm_duty_o)
  );

  pin_source pin_source_i (
    .ext_en_i(ext_en), .ext_level_i(ext_level),
    .unit_level_i(pin_o), .unit_oe_i(pin_oe_o), .pad_o(pin_i)
  );

  // Clock
  initial
  begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  // Counts one-cycle special event pulses
  always @(posedge clk_i)
  begin
    if (special_o === 1'h1)
      n_spec <= n_spec + 1;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  // Write one register; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awvalid_i <= 1'h1;
    awaddr_i <= a;
    wvalid_i <= 1'h1;
    wdata_i <= {24'h000000, v};
    bready_i <= 1'h1;
    do
    begin
      @(posedge clk_i);
      if (awvalid_i && awready_o)
        awvalid_i <= 1'h0;
      if (wvalid_i && wready_o)
        wvalid_i <= 1'h0;
      if (bready_i && bvalid_o)
      begin
        r = bresp_o;
      end
    end while (!(bready_i && bvalid_o));
  endtask

  task automatic rd(input logic [7:0] a);
    arvalid_i <= 1'h1;
    araddr_i <= a;
    rready_i <= 1'h1;
    do
    begin
      @(posedge clk_i);
      if (arvalid_i && arready_o)
        arvalid_i <= 1'h0;
      if (rvalid_o)
      begin
        d = rdata_o;
        r = rresp_o;
      end
    end while (!rvalid_o);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Select a mode, then clear a flag the change may have raised
  task automatic setm(input logic [3:0] m);
    wr(OFF_CTRL, {4'h0, m});
    wr(OFF_FLAG, 8'h01);
  endtask

  // One rise then one fall on the pad; the timer steps between them
  task automatic pulse();
    ext_level <= 1'h1;
    cyc(6);
    first_timer <= first_timer + 16'h0001;
    ext_level <= 1'h0;
    cyc(6);
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    cyc(20000);
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    {rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, port_latch} <= 7'h00;
    {awaddr_i, araddr_i, second_timer, fourth_timer} <= 32'h00000000;
    {ce_i, dir_in, ext_en, ext_level, wstrb_i} <= 8'hEF;
    {wdata_i, first_timer, third_timer} <= 64'h0000000000000000;
    cm = '{MODE_TOGGLE, MODE_CMP_HIGH, MODE_CMP_LOW, MODE_CMP_SOFT, MODE_CMP_SPECIAL};
    cyc(16);
    rst_n_i <= 1'h1;
    cyc(1);
    ext_level <= 1'h0;
    rchk(OFF_CTRL, 32'h0);
    rchk(OFF_FLAG, 32'h0);
    wr(8'h1C, 8'h55);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h1C);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFF_CTRL, 8'hFF);
    rchk(OFF_CTRL, 32'h3F);
    wr(OFF_DATA_LO, 8'hA5);
    rchk(OFF_DATA_LO, 32'hA5);
    wr(OFF_DATA_HI, 8'h5A);
    rchk(OFF_DATA_HI, 32'h5A);
    // A write without its low byte strobe changes nothing
    wstrb_i <= 4'hE;
    wr(OFF_DATA_HI, 8'h77);
    wstrb_i <= 4'hF;
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    rchk(OFF_DATA_HI, 32'h5A);
    // Edge kind and prescale of each capture mode
    for (k = 0; k < 4; k++)
    begin
      n = (k == 2) ? 4 : ((k == 3) ? 16 : 1);
      wr(OFF_CTRL, 8'h00);
      setm(MODE_CAP_FALL + 4'(k));
      first_timer <= 16'h1200;
      repeat (n - 1) pulse();
      chk({31'h0, flag_o}, 32'h0);
      pulse();
      chk({31'h0, flag_o}, 32'h1);
      rchk(OFF_DATA_LO, 32'(n - (k == 0 ? 0 : 1)));
    end
    // Second capture before any read replaces the first
    setm(MODE_CAP_RISE);
    first_timer <= 16'h3400;
    pulse();
    first_timer <= 16'h5600;
    pulse();
    rchk(OFF_DATA_HI, 32'h56);
    wr(OFF_FLAG, 8'h01);
    rchk(OFF_FLAG, 32'h0);
    // Switching off clears the prescaler; a direct prescale change keeps it
    setm(MODE_CAP_RISE4);
    repeat (2) pulse();
    wr(OFF_CTRL, 8'h00);
    setm(MODE_CAP_RISE4);
    repeat (3) pulse();
    chk({31'h0, flag_o}, 32'h0);
    setm(MODE_CAP_RISE16);
    repeat (12) pulse();
    chk({31'h0, flag_o}, 32'h0);
    pulse();
    chk({31'h0, flag_o}, 32'h1);
    // Every timer interconnect option
    third_timer <= 16'hBE00;
    for (k = 0; k < 4; k++)
    begin
      wr(OFF_TIMER_ASSIGN, 8'(k));
      setm(MODE_CAP_RISE);
      pulse();
      rchk(OFF_DATA_HI, k == 0 ? 32'h56 : 32'hBE);
    end
    wr(OFF_TIMER_ASSIGN, {6'h00, ASSIGN_ALL_LOW});
    // Port write seen on an output pad makes a capture; reserved code 1 does not
    {ext_en, dir_in} <= 2'h0;
    setm(MODE_CAP_RISE);
    port_latch <= 1'h1;
    cyc(6);
    chk({31'h0, flag_o}, 32'h1);
    setm(MODE_RSVD_A);
    port_latch <= 1'h0;
    cyc(6);
    port_latch <= 1'h1;
    cyc(6);
    chk({31'h0, flag_o}, 32'h0);
    // Compare actions on the pad, flag and special event
    {first_timer, port_latch} <= 17'h00001;
    wr(OFF_DATA_LO, 8'h00);
    wr(OFF_DATA_HI, 8'h01);
    wr(OFF_CTRL, 8'h00);
    for (k = 0; k < 5; k++)
    begin
      setm(cm[k]);
      s = n_spec;
      cyc(2);
      if (k < 4)
        chk({31'h0, pin_o}, {31'h0, 1'(5'b01100 >> k)});
      first_timer <= 16'h0100;
      cyc(3);
      first_timer <= 16'h0000;
      cyc(3);
      if (k < 4)
        chk({31'h0, pin_o}, {31'h0, 1'(5'b01011 >> k)});
      chk({31'h0, flag_o}, 32'h1);
      chk(n_spec - s, 32'(k == 4));
    end
    // Open-drain bit behind the shadow select
    wr(OFF_SHADOW, 8'h01);
    wr(OFF_FIRST_TIMER_HIGH_BYTE_OVERLAY, 8'h01);
    rchk(OFF_FIRST_TIMER_HIGH_BYTE_OVERLAY, 32'h1);
    wr(OFF_CTRL, 8'h00);
    setm(MODE_CMP_HIGH);
    cyc(2);
    chk({31'h0, pin_oe_o}, 32'h1);
    first_timer <= 16'h0100;
    cyc(3);
    chk({30'h0, pin_oe_o, pin_i}, 32'h1);
    first_timer <= 16'hC300;
    wr(OFF_SHADOW, 8'h00);
    rchk(OFF_FIRST_TIMER_HIGH_BYTE_OVERLAY, 32'hC3);
    // Duty value in each PWM code
    wr(OFF_DATA_LO, 8'hB4);
    for (k = 0; k < 4; k++)
    begin
      wr(OFF_CTRL, 8'((k << 4) | 12 | k));
      cyc(2);
      chk({22'h0, pwm_duty_o}, {22'h0, 8'hB4, 2'(k)});
    end
    wr(OFF_CTRL, 8'h00);
    cyc(2);
    chk({22'h0, pwm_duty_o}, 32'h0);
    give_verdict();
  end
endmodule
